// [rtl/tbl_link.sv]
/*
 * tone bus link controller: tone and message transmitter, polarisation
 * pin, receive qualifier and decoder, flags and an 8-entry receive fifo.
 * assumes: register strobes come from the 2-wire bus decoder already
 * synchronous to i_ref_clk; i_ref_clk is the crystal clock; the tone
 * line input is already synchronous.
 */
`timescale 1ns/1ps
`include "tbl_defs.svh"

// ----------------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------------
module tbl_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------------------------------------
// top
// ----------------------------------------------------------------------
module tbl_link #(
	parameter int UNIT_CYC  = `TBL_BIT_UNIT_US * `TBL_CLK_MHZ,
	parameter int GAP_CYC   = `TBL_GAP_US * `TBL_CLK_MHZ,
	parameter int EOM_CYC   = `TBL_EOM_US * `TBL_CLK_MHZ,
	parameter int SIL_CYC   = `TBL_SILENCE_US * `TBL_CLK_MHZ,
	parameter int BANK_SIZE = 8,
	parameter int FIFO_SIZE = 8
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_wdata,
	output logic [7:0]      o_reg_rdata,
	input  wire logic       i_rx_line,
	output logic            o_tone,
	output logic            o_polarisation_select,
	output logic            o_status,
	output logic            o_irq_b,
	output logic            o_rx_valid,
	output tbl_pkg::tbl_rx_byte_t o_rx_byte,
	input  wire logic       i_rx_ready
);
	logic [7:0] tone_mode_control;
	logic [7:0] tone_divider_ratio;
	logic [7:0] message_byte_load;
	logic [7:0] receive_control_one;
	logic [7:0] receive_control_two;
	logic [3:0] flags;
	logic [3:0] pending;
	logic       tx_done;
	logic [7:0] bank [BANK_SIZE];
	logic [2:0] load_ptr;

	logic wr_mode;
	logic rd_flags;
	logic tx_start;
	logic tx_end;
	logic msg_end;
	logic rx_reset;
	assign wr_mode  = i_reg_wr && (i_reg_addr == `TBL_OFS_MODE);
	assign rd_flags = i_reg_rd && (i_reg_addr == `TBL_OFS_FLAGS);
	assign tx_start = wr_mode && (i_reg_wdata[2:0] >= `TBL_TONE_BURST0)
		&& (i_reg_wdata[2:0] <= `TBL_TONE_MSG);
	assign rx_reset = i_reg_wr && (i_reg_addr == `TBL_OFS_CTRL1)
		&& i_reg_wdata[`TBL_CTRL1_RXRST_BIT];

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			tone_mode_control   <= `TBL_RST_MODE;
			tone_divider_ratio  <= `TBL_RST_RATIO;
			receive_control_one <= `TBL_RST_CTRL1;
			receive_control_two <= `TBL_RST_CTRL2;
		end else begin
			if (msg_end) begin
				tone_mode_control[5:0] <= 6'h00;
			end else if (wr_mode) begin
				tone_mode_control <= {1'b0, i_reg_wdata[6:0]};
			end
			if (i_reg_wr && i_reg_addr == `TBL_OFS_RATIO) begin
				tone_divider_ratio <= i_reg_wdata;
			end
			if (i_reg_wr && i_reg_addr == `TBL_OFS_CTRL1) begin
				// reset bit is never stored, so it reads back low
				receive_control_one <= {i_reg_wdata[7:5], 1'b0, i_reg_wdata[3:0]};
			end
			if (i_reg_wr && i_reg_addr == `TBL_OFS_CTRL2) begin
				receive_control_two <= i_reg_wdata;
			end
		end
	end

	// message bank, pointer rewinds when a transmission starts
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			load_ptr          <= 3'h0;
			message_byte_load <= 8'h00;
		end else if (tx_start) begin
			load_ptr <= 3'h0;
		end else if (i_reg_wr && i_reg_addr == `TBL_OFS_LOAD) begin
			bank[load_ptr]    <= i_reg_wdata;
			message_byte_load <= i_reg_wdata;
			load_ptr          <= load_ptr + 3'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`TBL_OFS_MODE:  o_reg_rdata <= tone_mode_control;
				`TBL_OFS_RATIO: o_reg_rdata <= tone_divider_ratio;
				`TBL_OFS_LOAD:  o_reg_rdata <= message_byte_load;
				`TBL_OFS_FLAGS: o_reg_rdata <= {pending, flags};
				`TBL_OFS_CTRL1: o_reg_rdata <= receive_control_one;
				`TBL_OFS_CTRL2: o_reg_rdata <= receive_control_two;
				default:        o_reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_polarisation_select <= 1'b0;
		end else begin
			o_polarisation_select <= tone_mode_control[`TBL_MODE_POL_BIT];
		end
	end

	// ------------------------------------------------------------------
	// tone generator
	// ------------------------------------------------------------------
	logic [10:0] ratio_eff;
	logic [11:0] half_cyc;
	logic [11:0] half_cnt;
	logic        tone_sq;
	assign ratio_eff = (tone_divider_ratio == 8'h00) ? 11'(`TBL_DEF_RATIO)
		: {3'h0, tone_divider_ratio};
	assign half_cyc = {ratio_eff, 1'b0};

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			half_cnt <= 12'h001;
			tone_sq  <= 1'b0;
		end else if (half_cnt >= half_cyc) begin
			half_cnt <= 12'h001;
			tone_sq  <= ~tone_sq;
		end else begin
			half_cnt <= half_cnt + 12'h001;
		end
	end

	// ------------------------------------------------------------------
	// transmit sequencer, time in half-millisecond units
	// ------------------------------------------------------------------
	tbl_pkg::tbl_tx_state_t tx_state;
	logic [31:0] tmr;
	logic [4:0]  unit_idx;
	logic [1:0]  slot;
	logic [3:0]  bit_idx;
	logic [2:0]  byte_idx;
	logic        tx_on;
	logic        cur_bit;
	logic [8:0]  cur_word;
	assign cur_word = {bank[byte_idx], ~^bank[byte_idx]};
	assign cur_bit  = cur_word[4'h8 - bit_idx];
	assign tx_end   = (tx_state == tbl_pkg::TBL_ST_TAIL) && (tmr == 32'h0);
	assign msg_end  = tx_end && (tone_mode_control[2:0] == `TBL_TONE_MSG);

	always_comb begin
		case (tx_state)
			tbl_pkg::TBL_ST_BITS:  tx_on = (slot == 2'h0) || (slot == 2'h1 && !cur_bit);
			tbl_pkg::TBL_ST_BURST: tx_on = (tone_mode_control[2:0] == `TBL_TONE_BURST0)
				|| (slot == 2'h0);
			tbl_pkg::TBL_ST_IDLE:  tx_on = (tone_mode_control[2:0] == `TBL_TONE_CONT);
			default:               tx_on = 1'b0;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			tx_state <= tbl_pkg::TBL_ST_IDLE;
			tmr      <= 32'h0;
			unit_idx <= 5'h0;
			slot     <= 2'h0;
			bit_idx  <= 4'h0;
			byte_idx <= 3'h0;
		end else if (tx_start) begin
			unit_idx <= 5'h0;
			slot     <= 2'h0;
			bit_idx  <= 4'h0;
			byte_idx <= 3'h0;
			if (i_reg_wdata[2:0] == `TBL_TONE_MSG) begin
				tx_state <= tbl_pkg::TBL_ST_LEAD;
				tmr      <= 32'(GAP_CYC - 1);
			end else begin
				tx_state <= tbl_pkg::TBL_ST_BURST;
				tmr      <= 32'(UNIT_CYC - 1);
			end
		end else if (tmr != 32'h0) begin
			tmr <= tmr - 32'h1;
		end else begin
			case (tx_state)
				tbl_pkg::TBL_ST_LEAD: begin
					tx_state <= tbl_pkg::TBL_ST_BITS;
					tmr      <= 32'(UNIT_CYC - 1);
				end
				tbl_pkg::TBL_ST_BITS: begin
					tmr  <= 32'(UNIT_CYC - 1);
					slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
					if (slot == 2'h2) begin
						bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
						if (bit_idx == 4'h8) begin
							byte_idx <= byte_idx + 3'h1;
							if (byte_idx == tone_mode_control[5:3]) begin
								tx_state <= tbl_pkg::TBL_ST_TAIL;
								tmr      <= 32'(GAP_CYC - 1);
							end
						end
					end
				end
				tbl_pkg::TBL_ST_BURST: begin
					slot     <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
					unit_idx <= unit_idx + 5'h1;
					if (unit_idx == 5'(`TBL_BURST_UNITS - 1)) begin
						tx_state <= tbl_pkg::TBL_ST_TAIL;
						tmr      <= 32'(GAP_CYC - 1);
					end else begin
						tmr <= 32'(UNIT_CYC - 1);
					end
				end
				tbl_pkg::TBL_ST_TAIL: tx_state <= tbl_pkg::TBL_ST_IDLE;
				tbl_pkg::TBL_ST_IDLE: tx_state <= tbl_pkg::TBL_ST_IDLE;
				default:              tx_state <= tbl_pkg::TBL_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_tone <= 1'b0;
		end else begin
			o_tone <= tx_on & tone_sq;
		end
	end

	// transmit completion is sticky until the next mode write; set wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			tx_done <= 1'b0;
		end else if (tx_end) begin
			tx_done <= 1'b1;
		end else if (wr_mode) begin
			tx_done <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// receive qualifier: period window, extension, minimum pulse
	// ------------------------------------------------------------------
	logic [16:0] min_tone;
	logic [16:0] max_tone;
	logic [16:0] ext_len;
	logic [16:0] min_puls;
	logic [16:0] per_cnt;
	logic [16:0] ext_cnt;
	logic [16:0] env_len;
	logic        line_d;
	logic        clean;
	logic        armed;

	always_comb begin
		case (receive_control_one[7:6])
			2'h0:    min_tone = 17'((ratio_eff * 6'd24) >> 3);
			2'h1:    min_tone = 17'((ratio_eff * 6'd25) >> 3);
			2'h2:    min_tone = 17'((ratio_eff * 6'd23) >> 3);
			default: min_tone = 17'((ratio_eff * 6'd22) >> 3);
		endcase
		case (receive_control_two[1:0])
			2'h0:    max_tone = 17'((ratio_eff * 6'd48) >> 3);
			2'h1:    max_tone = 17'((ratio_eff * 6'd50) >> 3);
			2'h2:    max_tone = 17'((ratio_eff * 6'd46) >> 3);
			default: max_tone = 17'((ratio_eff * 6'd44) >> 3);
		endcase
		ext_len  = 17'(ratio_eff * (5'd7 + 5'(receive_control_two[4:2])));
		min_puls = 17'(ratio_eff * (5'd24 + 5'(receive_control_two[7:5])));
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			line_d  <= 1'b0;
			per_cnt <= 17'h0;
			ext_cnt <= 17'h0;
			env_len <= 17'h0;
			clean   <= 1'b0;
		end else begin
			line_d <= i_rx_line;
			if (i_rx_line && !line_d) begin
				per_cnt <= 17'h1;
				if (per_cnt >= min_tone && per_cnt <= max_tone) begin
					ext_cnt <= ext_len;
				end
			end else begin
				if (per_cnt != 17'h1ffff) begin
					per_cnt <= per_cnt + 17'h1;
				end
				if (ext_cnt != 17'h0) begin
					ext_cnt <= ext_cnt - 17'h1;
				end
			end
			// short bursts are noise, so the clean envelope waits out min_puls
			env_len <= (ext_cnt != 17'h0 && env_len != 17'h1ffff) ? env_len + 17'h1
				: (ext_cnt != 17'h0 ? env_len : 17'h0);
			clean   <= (ext_cnt != 17'h0) && (clean || env_len >= min_puls);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_status <= 1'b0;
		end else begin
			o_status <= receive_control_one[`TBL_CTRL1_DIAG_BIT] & clean;
		end
	end

	// ------------------------------------------------------------------
	// receive decoder
	// ------------------------------------------------------------------
	logic        clean_d;
	logic [31:0] ton;
	logic [31:0] sil;
	logic [3:0]  rx_bits;
	logic [8:0]  rx_shift;
	logic        had_byte;
	logic        ev_byte;
	logic        ev_eom;
	logic        ev_err;
	logic        ev_sil;
	logic        fifo_ready;
	logic        pop;
	logic        bit_val;
	tbl_pkg::tbl_rx_byte_t rx_word;
	assign bit_val = (ton < 32'((UNIT_CYC * 3) / 2));
	assign pop     = o_rx_valid & i_rx_ready;
	assign rx_word.data    = rx_shift[7:0];
	assign rx_word.parity  = bit_val;
	assign rx_word.par_err = ~(^{rx_shift[7:0], bit_val});

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			armed <= 1'b1;
		end else if (rx_reset || tx_start) begin
			armed <= 1'b0;
		end else if (tx_end) begin
			armed <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			clean_d  <= 1'b0;
			ton      <= 32'h0;
			sil      <= 32'h0;
			rx_bits  <= 4'h0;
			rx_shift <= 9'h0;
			had_byte <= 1'b0;
			ev_byte  <= 1'b0;
			ev_eom   <= 1'b0;
			ev_err   <= 1'b0;
			ev_sil   <= 1'b0;
		end else begin
			clean_d <= clean;
			ev_byte <= 1'b0;
			ev_eom  <= 1'b0;
			ev_err  <= 1'b0;
			ev_sil  <= 1'b0;
			if (!armed) begin
				ton      <= 32'h0;
				sil      <= 32'h0;
				rx_bits  <= 4'h0;
				had_byte <= 1'b0;
			end else if (clean) begin
				sil <= 32'h0;
				ton <= clean_d ? ton + 32'h1 : 32'(min_puls);
				if (ton == 32'(UNIT_CYC * 3) && rx_bits != 4'h0) begin
					ev_err  <= 1'b1;
					rx_bits <= 4'h0;
				end
			end else begin
				if (sil != 32'hffffffff) begin
					sil <= sil + 32'h1;
				end
				if (clean_d && ton <= 32'(UNIT_CYC * 3)) begin
					rx_shift <= {rx_shift[7:0], bit_val};
					rx_bits  <= (rx_bits == 4'h8) ? 4'h0 : rx_bits + 4'h1;
					if (rx_bits == 4'h8) begin
						ev_byte  <= fifo_ready;
						had_byte <= 1'b1;
					end
				end
				if (sil == 32'(UNIT_CYC * 3) && rx_bits != 4'h0) begin
					ev_err  <= 1'b1;
					rx_bits <= 4'h0;
				end
				if (sil == 32'(EOM_CYC) && had_byte) begin
					ev_eom   <= 1'b1;
					had_byte <= 1'b0;
				end
				if (sil == 32'(SIL_CYC)) begin
					ev_sil <= 1'b1;
				end
			end
		end
	end

	// bytes that arrive while the fifo is full are lost but still counted
	logic cnt_inc;
	assign cnt_inc = clean_d && !clean && armed && rx_bits == 4'h8 && ton <= 32'(UNIT_CYC * 3);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pending <= 4'h0;
		end else if (cnt_inc && !pop) begin
			pending <= (pending == 4'hf) ? pending : pending + 4'h1;
		end else if (pop && !cnt_inc && pending != 4'h0) begin
			pending <= pending - 4'h1;
		end
	end

	// new events beat the read-clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			flags <= 4'h0;
		end else begin
			flags <= ((rd_flags ? 4'h0 : flags) | {ev_sil, ev_err, ev_eom, ev_byte});
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_irq_b <= 1'b1;
		end else begin
			o_irq_b <= ~(|(flags & receive_control_one[3:0]) | tx_done);
		end
	end

	tbl_fifo #(
		.WIDTH($bits(tbl_pkg::tbl_rx_byte_t)),
		.DEPTH(FIFO_SIZE)
	) u_fifo (
		.i_ref_clk  (i_ref_clk),
		.i_rst_b    (i_rst_b),
		.i_in_valid (cnt_inc),
		.i_in_data  (rx_word),
		.o_in_ready (fifo_ready),
		.o_out_valid(o_rx_valid),
		.o_out_data (o_rx_byte),
		.i_out_ready(i_rx_ready)
	);
endmodule

// [inc/tbl_defs.svh]
/*
 * constants of the tone bus link controller: register offsets, field
 * positions, reset values and timing figures.
 * assumes: included by the design file by bare name.
 */
`ifndef TBL_DEFS_SVH
`define TBL_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TBL_OFS_MODE        8'h16
`define TBL_OFS_RATIO       8'h23
`define TBL_OFS_LOAD        8'h24
`define TBL_OFS_FLAGS       8'h76
`define TBL_OFS_CTRL1       8'h79
`define TBL_OFS_CTRL2       8'h7a

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define TBL_RST_MODE        8'h00
`define TBL_RST_RATIO       8'h00
`define TBL_RST_CTRL1       8'h00
`define TBL_RST_CTRL2       8'hd4
`define TBL_MODE_POL_BIT    6
`define TBL_CTRL1_DIAG_BIT  5
`define TBL_CTRL1_RXRST_BIT 4
`define TBL_TONE_OFF        3'h0
`define TBL_TONE_CONT       3'h1
`define TBL_TONE_BURST0     3'h2
`define TBL_TONE_BURST1     3'h3
`define TBL_TONE_MSG        3'h4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TBL_CLK_MHZ         100
`define TBL_DEF_TONE_HZ     22000
`define TBL_BIT_UNIT_US     500
`define TBL_GAP_US          16000
`define TBL_BURST_US        12500
`define TBL_EOM_US          6000
`define TBL_SILENCE_US      176000
`define TBL_BURST_UNITS     (`TBL_BURST_US / `TBL_BIT_UNIT_US)
`define TBL_DEF_RATIO       ((`TBL_CLK_MHZ * 1000000) / (4 * `TBL_DEF_TONE_HZ))

`endif

// [inc/tbl_pkg.sv]
/*
 * types of the tone bus link controller.
 * assumes: tbl_defs.svh holds the numbers.
 */
package tbl_pkg;

	typedef enum logic [2:0] {
		TBL_ST_IDLE  = 3'h0,
		TBL_ST_LEAD  = 3'h1,
		TBL_ST_BITS  = 3'h2,
		TBL_ST_BURST = 3'h3,
		TBL_ST_TAIL  = 3'h4
	} tbl_tx_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       par_err;
		logic       parity;
	} tbl_rx_byte_t;

endpackage

// [sim/tbl_link_properties.sv]
/*
 checker on the ports of the tone bus link controller, with its bind.
 assumes: one clock domain, synchronous active-low reset.
*/
`timescale 1ns/1ps
module tbl_link_properties (
	input wire logic                  i_ref_clk,
	input wire logic                  i_rst_b,
	input wire logic [7:0]            i_reg_addr,
	input wire logic                  i_reg_wr,
	input wire logic                  i_reg_rd,
	input wire logic [7:0]            i_reg_wdata,
	input wire logic [7:0]            o_reg_rdata,
	input wire logic                  o_tone,
	input wire logic                  o_polarisation_select,
	input wire logic                  o_status,
	input wire logic                  o_irq_b,
	input wire logic                  o_rx_valid,
	input wire tbl_pkg::tbl_rx_byte_t o_rx_byte,
	input wire logic                  i_rx_ready
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	// ----
	// shadows of written fields
	// ----
	logic       diag;
	logic [2:0] mode_w;
	logic [3:0] quiet;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			diag <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == 8'h79) begin
			diag <= i_reg_wdata[5];
		end
	end

	// quiet saturates: only the first cycles after a mode write matter
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			mode_w <= 3'h0;
			quiet  <= 4'h0;
		end else if (i_reg_wr && i_reg_addr == 8'h16) begin
			mode_w <= i_reg_wdata[2:0];
			quiet  <= 4'h0;
		end else if (quiet != 4'hf) begin
			quiet <= quiet + 4'h1;
		end
	end

	// ----
	// assertions
	// ----
	a_reset_quiet: assert property (
		$rose(i_rst_b) |-> o_irq_b && !o_tone && !o_rx_valid && !o_polarisation_select)
		else $error("outputs not idle after reset");
	a_pol_follows: assert property (
		i_reg_wr && i_reg_addr == 8'h16 |-> ##2 o_polarisation_select == $past(i_reg_wdata[6], 2))
		else $error("polarisation pin not following mode bit");
	a_mode_top_zero: assert property (
		i_reg_rd && i_reg_addr == 8'h16 |=> !o_reg_rdata[7])
		else $error("reserved mode bit read high");
	a_rxrst_clear: assert property (
		i_reg_rd && i_reg_addr == 8'h79 |=> !o_reg_rdata[4])
		else $error("receiver reset bit not self clearing");
	a_status_gated: assert property (
		!diag [*4] |-> !o_status)
		else $error("status pin active without diagnostic bit");
	a_tone_off: assert property (
		mode_w inside {3'h0, 3'h5, 3'h6, 3'h7} && quiet > 4'h3 |-> !o_tone)
		else $error("tone present in off or reserved mode");
	a_fifo_hold: assert property (
		o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_byte))
		else $error("fifo head changed while stalled");
	a_pending_valid: assert property (
		i_reg_rd && i_reg_addr == 8'h76 && o_rx_valid |=> o_reg_rdata[7:4] != 4'h0)
		else $error("pending count disagrees with fifo");

	c_irq: cover property ($fell(o_irq_b));
	c_pop: cover property (o_rx_valid && i_rx_ready);
	c_status: cover property (o_status);
endmodule

bind tbl_link tbl_link_properties tbl_link_properties_i (.i_ref_clk, .i_rst_b, .i_reg_addr, .i_reg_wr,
	.i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_tone, .o_polarisation_select, .o_status, .o_irq_b,
	.o_rx_valid, .o_rx_byte, .i_rx_ready);

// [sim/tbl_line_model.sv]
/*
 far-side equipment on the tone line: decodes sent bits, replies with tone.
 assumes: silence on the line is a low level.
*/
`timescale 1ns/1ps
module tbl_line_model #(
	parameter int UNIT = 150,
	parameter int HALF = 6
) (
	input  wire logic i_clk,
	input  wire logic i_tone,
	output logic      o_line
);
	int   age;
	int   on;
	int   run;
	int   tog;
	logic env;
	logic prev;
	logic bits[$];

	initial begin
		o_line = 1'b0;
		env = 1'b0;
		prev = 1'b0;
		age = 0;
		on = 0;
		tog = 0;
	end

	// ----
	// envelope decoder; 40 idle cycles end a burst of tone
	// ----
	always @(posedge i_clk) begin
		if (i_tone !== prev) begin
			run = age + 1;
			age = 0;
			tog++;
			env = 1'b1;
		end else begin
			age++;
		end
		prev = i_tone;
		if (env) begin
			on++;
		end
		if (env && age == 40) begin
			bits.push_back(on - 40 < UNIT * 3 / 2);
			env = 1'b0;
			on = 0;
		end
	end

	// sends the first n of nine bits, msb first
	task automatic send(input int n, input logic [8:0] v);
		int t;
		for (int i = 0; i < n; i++) begin
			t = v[8 - i] ? UNIT : 2 * UNIT;
			for (int k = 0; k < 3 * UNIT; k++) begin
				@(posedge i_clk);
				o_line <= (k < t) && ((k / HALF) % 2 == 0);
			end
		end
	endtask
endmodule

// [sim/test_tbl_link.sv]
/*
 self-checking bench of the tone bus link controller.
 assumes: shortened unit, gap and silence counts; ratio 3 for traffic.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_tbl_link;
	localparam int U = 150;
	localparam int G = 400;
	localparam int E = 600;
	localparam int S = 1500;
	localparam int R = 3;
	logic       clk, rst_b, wr, rd, rx_line, rx_ready, tone, pol, status, irq_b, rx_valid, st_seen;
	logic [7:0] addr, wdata, rdata, b;
	logic [8:0] v;
	logic [8:0] q[$];
	logic       eb[$];
	logic [7:0] ofs[7] = '{8'h16, 8'h23, 8'h24, 8'h76, 8'h79, 8'h7a, 8'h00};
	logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hd4, 8'h00};
	int         md[2] = '{2, 3};
	int         rt[2] = '{0, R};
	int         miscompares, n_checks, cyc, seed, pend, t0;
	tbl_pkg::tbl_rx_byte_t rx_byte;

	tbl_link #(.UNIT_CYC(U), .GAP_CYC(G), .EOM_CYC(E), .SIL_CYC(S)) tbl_link_i (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_line(rx_line), .o_tone(tone),
		.o_polarisation_select(pol), .o_status(status), .o_irq_b(irq_b), .o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte), .i_rx_ready(rx_ready));
	tbl_line_model #(.UNIT(U), .HALF(2 * R)) tbl_line_model_i (.i_clk(clk), .i_tone(tone), .o_line(rx_line));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (status === 1'b1) st_seen <= 1'b1;
	end

	// ----
	// bus cycles and helpers
	// ----
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(nm, e & m, rdata & m)
	endtask
	function automatic logic [8:0] par(input logic [7:0] d);
		return {d, ~^d};
	endfunction
	task automatic rxb(input logic [8:0] w);
		q.push_back(w);
		pend++;
		tbl_line_model_i.send(9, w);
	endtask
	task automatic pop(input logic [8:0] w);
		`CHK("rx valid", 1'b1, rx_valid)
		`CHK("rx byte", {w[8:1], ~^w, w[0]}, rx_byte)
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
		#1 pend--;
	endtask
	// bounded: a missing interrupt shows up in the timing compare
	task automatic waitirq;
		int n = 0;
		// a sticky completion irq only drops two edges after the mode write
		repeat (2) @(posedge clk);
		while (irq_b !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge clk);
		miscompares++;
		test_done;
	end

	// ----
	// scenarios
	// ----
	initial begin
		seed = 32'he189;
		{cyc, miscompares, n_checks, pend, st_seen} = '0;
		{rst_b, wr, rd, addr, wdata, rx_ready} = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		foreach (ofs[i]) rreg(ofs[i], 8'hff, rv[i], "reset value");
		wreg(8'h16, 8'hc0);
		rreg(8'h16, 8'hff, 8'h40, "mode");
		`CHK("pol", 1'b1, pol)
		// no receiver reset yet: it would disarm reception until a transmission ends
		wreg(8'h79, 8'h0f);
		rreg(8'h79, 8'hff, 8'h0f, "ctrl1");
		foreach (rt[i]) begin
			wreg(8'h23, rt[i][7:0]);
			wreg(8'h16, 8'h01);
			repeat (rt[i] != 0 ? 40 : 7000) @(posedge clk);
			`CHK("half period", rt[i] != 0 ? 2 * rt[i] : 2272, tbl_line_model_i.run)
		end
		wreg(8'h16, 8'h00);
		repeat (20) @(posedge clk);
		t0 = tbl_line_model_i.tog;
		repeat (100) @(posedge clk);
		`CHK("tone off", t0, tbl_line_model_i.tog)
		// two bytes, the second with a broken parity bit
		wreg(8'h79, 8'h21);
		for (int i = 0; i < 2; i++) rxb(par(8'($random(seed))) ^ 9'(i));
		repeat (E + 50) @(posedge clk);
		`CHK("irq", 1'b0, irq_b)
		`CHK("status", 1'b1, st_seen)
		rreg(8'h76, 8'hf7, {pend[3:0], 4'h3}, "flags");
		rreg(8'h76, 8'hf7, {pend[3:0], 4'h0}, "flags");
		`CHK("irq", 1'b1, irq_b)
		while (q.size() > 0) pop(q.pop_front());
		repeat (S) @(posedge clk);
		rreg(8'h76, 8'hff, 8'h08, "silence");
		tbl_line_model_i.send(4, 9'h1ff);
		repeat (5 * U) @(posedge clk);
		rreg(8'h76, 8'h04, 8'h04, "lost bit");
		wreg(8'h79, 8'h10);
		rreg(8'h79, 8'hff, 8'h00, "ctrl1 reset bit");
		tbl_line_model_i.send(9, par(8'h5a));
		repeat (E + 50) @(posedge clk);
		rreg(8'h76, 8'hf3, 8'h00, "rx reset");
		// three loaded bytes, polarisation kept across completion
		for (int i = 0; i < 3; i++) begin
			b = 8'($random(seed));
			v = par(b);
			wreg(8'h24, b);
			for (int k = 8; k >= 0; k--) eb.push_back(v[k]);
		end
		tbl_line_model_i.bits.delete();
		t0 = cyc;
		wreg(8'h16, 8'h54);
		waitirq;
		`CHK("msg time", 1'b1, (cyc - t0) inside {[2 * G + 81 * U : 2 * G + 81 * U + 12]})
		`CHK("msg bits", 1'b1, tbl_line_model_i.bits == eb)
		rreg(8'h16, 8'hff, 8'h40, "mode cleared");
		foreach (md[i]) begin
			tbl_line_model_i.bits.delete();
			t0 = cyc;
			wreg(8'h16, md[i][7:0]);
			waitirq;
			`CHK("burst time", 1'b1, (cyc - t0) inside {[25 * U + G : 25 * U + G + 12]})
			`CHK("burst pulses", md[i] == 2 ? 1 : 9, tbl_line_model_i.bits.size())
			`CHK("burst bit", md[i] == 3, tbl_line_model_i.bits[0])
			rreg(8'h16, 8'h3f, md[i][7:0], "burst mode");
		end
		wreg(8'h16, 8'h00);
		// fill past the depth with the consumer stalled, then drain
		for (int i = 0; i < 9; i++) rxb(par(8'($random(seed))));
		repeat (E) @(posedge clk);
		rreg(8'h76, 8'hf0, {pend[3:0], 4'h0}, "pending");
		void'(q.pop_back());
		while (q.size() > 0) pop(q.pop_front());
		`CHK("fifo empty", 1'b0, rx_valid)
		rreg(8'h76, 8'hf0, {pend[3:0], 4'h0}, "pending");
		test_done;
	end
endmodule
